// *** two_wire_pkg.sv ***
// Shared constants for the two-wire register link ends
package two_wire_pkg;
  // Target address after reset; write form of the address byte is 8'h7A
  localparam logic [6:0] DEV_ADDR_RST = 7'h3D;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  // Timing of the host-made serial clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Byte slots of a write as the device sees them
  localparam logic [1:0] IDX_AHI = 2'h0;
  localparam logic [1:0] IDX_ALO = 2'h1;
  localparam logic [1:0] IDX_DHI = 2'h2;
  localparam logic [1:0] IDX_DLO = 2'h3;
  // Host command kinds
  typedef enum logic [1:0] {
    CMD_WRITE = 2'h0,
    CMD_RAND_READ = 2'h1,
    CMD_CUR_READ = 2'h2
  } cmd_kind_t;
endpackage : two_wire_pkg

// *** two_wire_if.sv ***
// Two-wire link between host and device, with open-drain wire resolution
`timescale 1ns/1ps
interface two_wire_if;
  logic serial_clock;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic serial_data_line;
  // Line is pulled high unless an enabled party pulls it low
  assign serial_data_line = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));
  modport device (
    input serial_clock,
    input serial_data_line,
    output dev_sda_o,
    output dev_sda_oe_n
  );
  modport host (
    output serial_clock,
    output host_sda_o,
    output host_sda_oe_n,
    input serial_data_line
  );
endinterface : two_wire_if

// *** two_wire_host.sv ***
// Host end: makes the serial clock and runs write and read sequences
`timescale 1ns/1ps
module two_wire_host
  import two_wire_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  two_wire_if.host bus,
  input wire logic cmd_valid_i,
  input wire cmd_kind_t cmd_kind_i,
  input wire logic [15:0] cmd_addr_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic [7:0] cmd_len_i,
  output logic cmd_ready_o,
  output logic wdata_take_o,
  output logic [15:0] rdata_o,
  output logic rdata_valid_o,
  output logic done_o,
  output logic nak_o
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_STA = 3'b001, H_BIT = 3'b011, H_ACK = 3'b010, H_STO = 3'b110
  } hstate_t;
  typedef enum logic [2:0] {
    S_ADW, S_AHI, S_ALO, S_WHI, S_WLO, S_RSTA, S_ADR, S_RD
  } stage_t;

  hstate_t st_q;
  stage_t stage_q;
  cmd_kind_t kind_q;
  logic [7:0] div_q;
  logic tick_q;
  logic [1:0] ph_q;
  logic [2:0] bit_q;
  logic [7:0] sr_q;
  logic rd_mode_q;
  logic ack_in_q;
  logic scl_q;
  logic oe_n_q;
  logic [15:0] addr_q;
  logic [15:0] word_q;
  logic [7:0] words_q;
  logic [8:0] rd_left_q;
  logic rd_lo_q;
  logic [7:0] rd_hi_q;

  assign bus.serial_clock = scl_q;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe_n = oe_n_q;

  // Quarter-period enable; four quarters make one serial clock period
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == QTR_LAST);
      div_q <= (div_q == QTR_LAST) ? 8'h00 : div_q + 8'h01;
    end
  end

  // Bit engine and byte sequencer
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= H_IDLE;
      stage_q <= S_ADW;
      kind_q <= CMD_WRITE;
      ph_q <= 2'h0;
      bit_q <= 3'h0;
      sr_q <= 8'h00;
      rd_mode_q <= 1'b0;
      ack_in_q <= 1'b0;
      scl_q <= 1'b1;
      oe_n_q <= 1'b1;
      addr_q <= 16'h0000;
      word_q <= 16'h0000;
      words_q <= 8'h00;
      rd_left_q <= 9'h000;
      rd_lo_q <= 1'b0;
      rd_hi_q <= 8'h00;
      cmd_ready_o <= 1'b1;
      wdata_take_o <= 1'b0;
      rdata_o <= 16'h0000;
      rdata_valid_o <= 1'b0;
      done_o <= 1'b0;
      nak_o <= 1'b0;
    end else begin
      wdata_take_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      done_o <= 1'b0;
      if (st_q == H_IDLE) begin
        if (cmd_valid_i && cmd_ready_o && cmd_len_i != 8'h00) begin
          kind_q <= cmd_kind_i;
          addr_q <= cmd_addr_i;
          words_q <= cmd_len_i;
          rd_left_q <= {cmd_len_i, 1'b0};
          rd_lo_q <= 1'b0;
          rd_mode_q <= 1'b0;
          nak_o <= 1'b0;
          cmd_ready_o <= 1'b0;
          ph_q <= 2'h0;
          // Current-location read skips the address phase entirely
          if (cmd_kind_i == CMD_CUR_READ) begin
            stage_q <= S_ADR;
            sr_q <= {DEV_ADDR_RST, DIR_READ};
          end else begin
            stage_q <= S_ADW;
            sr_q <= {DEV_ADDR_RST, DIR_WRITE};
          end
          st_q <= H_STA;
        end
      end else if (tick_q) begin
        ph_q <= ph_q + 2'h1;
        unique case (st_q)
          H_STA: begin
            // Release, raise clock, pull data low while clock high
            unique case (ph_q)
              2'h0: oe_n_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: oe_n_q <= 1'b0;
              2'h3: begin
                scl_q <= 1'b0;
                bit_q <= 3'h0;
                st_q <= H_BIT;
              end
            endcase
          end
          H_BIT: begin
            unique case (ph_q)
              2'h0: oe_n_q <= rd_mode_q ? 1'b1 : sr_q[7];
              2'h1: scl_q <= 1'b1;
              2'h2: if (rd_mode_q) sr_q <= {sr_q[6:0], bus.serial_data_line};
              2'h3: begin
                scl_q <= 1'b0;
                if (!rd_mode_q) sr_q <= {sr_q[6:0], 1'b0};
                bit_q <= bit_q + 3'h1;
                if (bit_q == LAST_BIT) st_q <= H_ACK;
              end
            endcase
          end
          H_ACK: begin
            unique case (ph_q)
              // Reads: ack every byte but the last, which gets a nak
              2'h0: oe_n_q <= rd_mode_q ? (rd_left_q == 9'h001) : 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: ack_in_q <= !bus.serial_data_line;
              2'h3: begin
                scl_q <= 1'b0;
                st_q <= H_BIT;
                if (!rd_mode_q && !ack_in_q) begin
                  nak_o <= 1'b1;
                  st_q <= H_STO;
                end else begin
                  unique case (stage_q)
                    S_ADW: begin
                      stage_q <= S_AHI;
                      sr_q <= addr_q[15:8];
                    end
                    S_AHI: begin
                      stage_q <= S_ALO;
                      sr_q <= addr_q[7:0];
                    end
                    S_ALO: begin
                      if (kind_q == CMD_WRITE) begin
                        stage_q <= S_WHI;
                        word_q <= cmd_wdata_i;
                        sr_q <= cmd_wdata_i[15:8];
                        wdata_take_o <= 1'b1;
                      end else begin
                        stage_q <= S_RSTA;
                        sr_q <= {DEV_ADDR_RST, DIR_READ};
                        st_q <= H_STA;
                      end
                    end
                    S_WHI: begin
                      stage_q <= S_WLO;
                      sr_q <= word_q[7:0];
                    end
                    S_WLO: begin
                      words_q <= words_q - 8'h01;
                      if (words_q == 8'h01) begin
                        st_q <= H_STO;
                      end else begin
                        stage_q <= S_WHI;
                        word_q <= cmd_wdata_i;
                        sr_q <= cmd_wdata_i[15:8];
                        wdata_take_o <= 1'b1;
                      end
                    end
                    // Read address byte acked, after a restart or directly
                    S_RSTA, S_ADR: begin
                      stage_q <= S_RD;
                      rd_mode_q <= 1'b1;
                    end
                    S_RD: begin
                      rd_left_q <= rd_left_q - 9'h001;
                      rd_lo_q <= !rd_lo_q;
                      if (rd_lo_q) begin
                        rdata_o <= {rd_hi_q, sr_q};
                        rdata_valid_o <= 1'b1;
                      end else begin
                        rd_hi_q <= sr_q;
                      end
                      if (rd_left_q == 9'h001) st_q <= H_STO;
                    end
                  endcase
                end
              end
            endcase
          end
          H_STO: begin
            // Pull low, raise clock, release data while clock high
            unique case (ph_q)
              2'h0: oe_n_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: oe_n_q <= 1'b1;
              2'h3: begin
                st_q <= H_IDLE;
                done_o <= 1'b1;
                cmd_ready_o <= 1'b1;
              end
            endcase
          end
          default: st_q <= H_IDLE;
        endcase
      end
    end
  end
endmodule : two_wire_host

// *** two_wire_device.sv ***
// Device end: register target of the two-wire link with 16-bit addresses
// Summary of operation
// - First byte: seven-bit address, then direction bit
// - Answers address byte 0x7A after reset
// - Host always uses 16-bit address and data
// - Transmitter releases line for acknowledge clock
// - Acknowledge is line low; high means nak
// - Data changes only while clock is low
// - Host naks last wanted read byte
// - Acknowledge only own address; else stay silent
// - Write: two address, two data bytes, acked
// - Host ends write with stop or restart
// - Random read: address write, restart, read
// - Host acks wanted bytes, naks to stop
// - Read without address uses retained address
// - Keep sending bytes while host acknowledges
// - High-order byte first for address and data
// - Sequential write accepts words until stop
// - Bytes shift most significant bit first
// - Start and stop: data edges, clock high
// - Single-byte register addressing not supported
`timescale 1ns/1ps
module two_wire_device
  import two_wire_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  two_wire_if.device bus,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [15:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i
);
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_ADDR = 3'b001, D_ACK = 3'b011, D_RX = 3'b010,
    D_TX = 3'b110, D_RACK = 3'b111
  } dstate_t;

  dstate_t st_q;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic dir_q;
  logic [1:0] idx_q;
  logic [7:0] ahi_q;
  logic [7:0] dhi_q;
  logic [15:0] ptr_q;
  logic [15:0] rd_word_q;
  logic rd_cap_q;
  logic tx_lo_q;
  logic ack_seen_q;
  logic oe_n_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = oe_n_q;

  // Line conditions judged against the previous sample
  assign scl_rise = bus.serial_clock && !scl_q;
  assign scl_fall = !bus.serial_clock && scl_q;
  assign start_det = bus.serial_clock && scl_q && sda_q && !bus.serial_data_line;
  assign stop_det = bus.serial_clock && scl_q && !sda_q && bus.serial_data_line;

  // Previous line levels; inputs are already synchronous
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.serial_clock;
      sda_q <= bus.serial_data_line;
    end
  end

  // Read word capture one cycle after the fetch strobe
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_cap_q <= 1'b0;
      rd_word_q <= 16'h0000;
    end else begin
      rd_cap_q <= reg_rd_o;
      if (rd_cap_q) rd_word_q <= reg_rdata_i;
    end
  end

  // Protocol engine; start and stop take priority over bit traffic
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= D_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      dir_q <= DIR_WRITE;
      idx_q <= IDX_AHI;
      ahi_q <= 8'h00;
      dhi_q <= 8'h00;
      ptr_q <= 16'h0000;
      tx_lo_q <= 1'b0;
      ack_seen_q <= 1'b0;
      oe_n_q <= 1'b1;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_addr_o <= 16'h0000;
      reg_wdata_o <= 16'h0000;
    end else begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      if (start_det) begin
        // Restart also lands here; a half-sent address is dropped
        st_q <= D_ADDR;
        cnt_q <= 4'h0;
        oe_n_q <= 1'b1;
      end else if (stop_det) begin
        st_q <= D_IDLE;
        oe_n_q <= 1'b1;
      end else begin
        unique case (st_q)
          D_IDLE: oe_n_q <= 1'b1;
          D_ADDR, D_RX: begin
            if (scl_rise && cnt_q != BITS_PER_BYTE) begin
              sr_q <= {sr_q[6:0], bus.serial_data_line};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
              cnt_q <= 4'h0;
              if (st_q == D_ADDR) begin
                if (sr_q[7:1] == DEV_ADDR_RST) begin
                  oe_n_q <= 1'b0;
                  st_q <= D_ACK;
                  dir_q <= sr_q[0];
                  idx_q <= IDX_AHI;
                  tx_lo_q <= 1'b0;
                  if (sr_q[0] == DIR_READ) begin
                    // Fetch from the retained pointer for current reads
                    reg_rd_o <= 1'b1;
                    reg_addr_o <= ptr_q;
                  end
                end else begin
                  st_q <= D_IDLE;
                end
              end else begin
                oe_n_q <= 1'b0;
                st_q <= D_ACK;
                idx_q <= (idx_q == IDX_DLO) ? IDX_DHI : idx_q + 2'h1;
                unique case (idx_q)
                  IDX_AHI: ahi_q <= sr_q;
                  // Pointer changes only once both address bytes arrive
                  IDX_ALO: ptr_q <= {ahi_q, sr_q};
                  IDX_DHI: dhi_q <= sr_q;
                  IDX_DLO: begin
                    reg_wr_o <= 1'b1;
                    reg_addr_o <= ptr_q;
                    reg_wdata_o <= {dhi_q, sr_q};
                    ptr_q <= ptr_q + 16'h0001;
                  end
                endcase
              end
            end
          end
          D_ACK: begin
            if (scl_fall) begin
              // End of acknowledge clock: hand the line back or send
              if (dir_q == DIR_READ) begin
                sr_q <= {rd_word_q[14:8], 1'b0};
                oe_n_q <= rd_word_q[15];
                st_q <= D_TX;
              end else begin
                oe_n_q <= 1'b1;
                st_q <= D_RX;
              end
            end
          end
          D_TX: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == BITS_PER_BYTE) begin
                cnt_q <= 4'h0;
                oe_n_q <= 1'b1;
                st_q <= D_RACK;
              end else begin
                oe_n_q <= sr_q[7];
                sr_q <= {sr_q[6:0], 1'b0};
              end
            end
          end
          D_RACK: begin
            if (scl_rise) begin
              ack_seen_q <= !bus.serial_data_line;
            end else if (scl_fall) begin
              if (ack_seen_q) begin
                st_q <= D_TX;
                tx_lo_q <= !tx_lo_q;
                if (!tx_lo_q) begin
                  // Low byte goes out; prefetch the next word meanwhile
                  sr_q <= {rd_word_q[6:0], 1'b0};
                  oe_n_q <= rd_word_q[7];
                  ptr_q <= ptr_q + 16'h0001;
                  reg_rd_o <= 1'b1;
                  reg_addr_o <= ptr_q + 16'h0001;
                end else begin
                  sr_q <= {rd_word_q[14:8], 1'b0};
                  oe_n_q <= rd_word_q[15];
                end
              end else begin
                st_q <= D_IDLE;
                oe_n_q <= 1'b1;
              end
            end
          end
          default: st_q <= D_IDLE;
        endcase
      end
    end
  end
endmodule : two_wire_device

// *** two_wire_assertions.sv ***
// Link checker: open-drain use, data timing and silence of the device end
`timescale 1ns/1ps
module two_wire_assertions (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic serial_clock,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic serial_data_line
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  logic [8:0] hi_cnt_q;
  logic [3:0] lo_cnt_q;
  // Time with the serial clock high, saturating so idle never wraps
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_cnt_q <= 9'h000;
    end else if (!serial_clock) begin
      hi_cnt_q <= 9'h000;
    end else if (hi_cnt_q != 9'h1FF) begin
      hi_cnt_q <= hi_cnt_q + 9'h001;
    end
  end
  // Time since the serial clock fell, saturating
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lo_cnt_q <= 4'h0;
    end else if (serial_clock) begin
      lo_cnt_q <= 4'h0;
    end else if (lo_cnt_q != 4'hF) begin
      lo_cnt_q <= lo_cnt_q + 4'h1;
    end
  end
  a_dev_open_drain: assert property (dev_sda_o == 1'b0)
    else $error("device end drives the line high");
  a_host_open_drain: assert property (host_sda_o == 1'b0)
    else $error("host end drives the line high");
  a_dev_steady_high: assert property (serial_clock && $past(serial_clock) |-> $stable(dev_sda_oe_n))
    else $error("device changed the line while the clock was high");
  a_dev_no_start: assert property (
    $fell(serial_data_line) && serial_clock && $past(serial_clock) |-> dev_sda_oe_n)
    else $error("device made a start edge");
  a_dev_no_stop: assert property (
    $rose(serial_data_line) && serial_clock && $past(serial_clock) |-> $past(dev_sda_oe_n))
    else $error("device made a stop edge");
  a_drive_after_fall: assert property ($fell(dev_sda_oe_n) |-> !serial_clock && lo_cnt_q < 4'hA)
    else $error("device pulled the line low away from a clock fall");
  a_release_after_fall: assert property ($rose(dev_sda_oe_n) |-> !serial_clock && lo_cnt_q < 4'hA)
    else $error("device released the line away from a clock fall");
  a_ack_held_high: assert property (
    $rose(serial_clock) && !dev_sda_oe_n |-> !dev_sda_oe_n throughout ##[1:400] $fell(serial_clock))
    else $error("device low level not held through the clock high");
  a_quiet_when_idle: assert property (hi_cnt_q == 9'h1FF |-> dev_sda_oe_n)
    else $error("device holds the line on an idle bus");
  a_clock_low_min: assert property ($fell(serial_clock) |-> !serial_clock [*8])
    else $error("serial clock low phase too short");
endmodule : two_wire_assertions

// *** testbench.sv ***
// Self-checking bench: host and device ends joined over the two-wire link
`timescale 1ns/1ps
module testbench;
  import two_wire_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid, cmd_ready, wdata_take, rdata_valid, done, nak, reg_wr, reg_rd;
  logic pscl, psda, first;
  cmd_kind_t cmd_kind;
  logic [15:0] cmd_addr, cmd_wdata, rdata, reg_addr, reg_wdata, reg_rdata, ptr, base;
  logic [15:0] words [4];
  logic [7:0] cmd_len, mbyte;
  logic [15:0] exp_mem [bit [15:0]];
  logic [15:0] dev_mem [bit [15:0]];
  logic [15:0] wq[$], rq[$];
  logic [7:0] aq[$];
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int mcnt = 0;
  integer seed = 32'h315c;
  two_wire_if link ();
  two_wire_if link_b ();
  two_wire_host i_two_wire_host (.mclk_i(mclk_i), .rst_i(rst_i), .bus(link),
    .cmd_valid_i(cmd_valid), .cmd_kind_i(cmd_kind), .cmd_addr_i(cmd_addr),
    .cmd_wdata_i(cmd_wdata), .cmd_len_i(cmd_len), .cmd_ready_o(cmd_ready),
    .wdata_take_o(wdata_take), .rdata_o(rdata), .rdata_valid_o(rdata_valid),
    .done_o(done), .nak_o(nak));
  two_wire_device i_two_wire_device (.mclk_i(mclk_i), .rst_i(rst_i), .bus(link),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_rdata_i(reg_rdata));
  // Second device, driven by hand to probe address matching
  two_wire_device i_two_wire_device_b (.mclk_i(mclk_i), .rst_i(rst_i), .bus(link_b),
    .reg_wr_o(), .reg_rd_o(), .reg_addr_o(), .reg_wdata_o(), .reg_rdata_i(16'h0000));
  two_wire_assertions i_two_wire_assertions (.mclk_i(mclk_i), .rst_i(rst_i),
    .serial_clock(link.serial_clock), .host_sda_o(link.host_sda_o),
    .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe_n(link.dev_sda_oe_n), .serial_data_line(link.serial_data_line));

  always #4 mclk_i = !mclk_i;

  function automatic logic [15:0] dflt(input logic [15:0] a);
    return a ^ 16'h5A3C;
  endfunction : dflt

  task automatic close_out();
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Single-bit results: status flags and acknowledge levels
  task automatic cmp_flag(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_flag

  // Register file partner with the one-cycle read latency the device expects
  always @(posedge mclk_i) begin
    if (reg_wr === 1'b1)
      dev_mem[reg_addr] = reg_wdata;
    if (reg_rd === 1'b1)
      reg_rdata <= dev_mem.exists(reg_addr) ? dev_mem[reg_addr] : dflt(reg_addr);
  end

  // Result watcher: a write strobe retires the two oldest write notes, a read word the oldest read note
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 95000) begin
      bad_count++;
      close_out();
    end
    if (reg_wr === 1'b1) begin
      cmp("write addr", wq.size() != 0 ? wq.pop_front() : 16'hXXXX, reg_addr);
      cmp("write data", wq.size() != 0 ? wq.pop_front() : 16'hXXXX, reg_wdata);
    end
    if (rdata_valid === 1'b1)
      cmp("read word", rq.size() != 0 ? rq.pop_front() : 16'hXXXX, rdata);
  end

  // Wire watcher: address byte after each start and its acknowledge
  always @(posedge mclk_i) begin
    if (pscl && link.serial_clock && psda && !link.serial_data_line) begin
      mcnt = 0;
      first = 1'b1;
    end else if (!pscl && link.serial_clock && first) begin
      mbyte = {mbyte[6:0], link.serial_data_line};
      if (mcnt == 7)
        cmp("addr byte", {8'h00, aq.size() != 0 ? aq.pop_front() : 8'hXX}, {8'h00, mbyte});
      if (mcnt == 8) begin
        cmp_flag("addr ack", 1'b0, link.serial_data_line);
        first = 1'b0;
      end
      mcnt++;
    end
    pscl = link.serial_clock;
    psda = link.serial_data_line;
  end

  // One host command; notes every expected word before it is driven
  task automatic run(input cmd_kind_t k, input logic [15:0] a, input int n);
    int t;
    int i;
    t = 0;
    i = 0;
    if (k == CMD_WRITE) begin
      aq.push_back(8'h7A);
      for (int j = 0; j < n; j++) begin
        words[j] = 16'($random(seed));
        wq.push_back(a + 16'(j));
        wq.push_back(words[j]);
        exp_mem[a + 16'(j)] = words[j];
      end
      ptr = a + 16'(n);
    end else begin
      if (k == CMD_RAND_READ) begin
        aq.push_back(8'h7A);
        ptr = a;
      end
      aq.push_back(8'h7B);
      for (int j = 0; j < n; j++) begin
        rq.push_back(exp_mem.exists(ptr) ? exp_mem[ptr] : dflt(ptr));
        ptr++;
      end
    end
    while (cmd_ready !== 1'b1 && t < 1000) begin
      @(negedge mclk_i);
      t++;
    end
    cmd_kind = k;
    cmd_addr = a;
    cmd_len = 8'(n);
    cmd_wdata = words[0];
    cmd_valid = 1'b1;
    @(negedge mclk_i);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && t < 40000) begin
      @(negedge mclk_i);
      t++;
      if (wdata_take === 1'b1 && i < n - 1) begin
        i++;
        cmd_wdata = words[i];
      end
    end
    cmp_flag("done", 1'b1, done);
    cmp_flag("nak", 1'b0, nak);
  endtask : run

  // Hand-made address frame on the second link; quiet means no acknowledge
  task automatic probe(input logic [7:0] b, input logic quiet);
    logic seen;
    seen = 1'bX;
    link_b.host_sda_oe_n = 1'b0;
    repeat (2 * QTR_CYC) @(negedge mclk_i);
    for (int k = 8; k >= 0; k--) begin
      link_b.serial_clock = 1'b0;
      repeat (QTR_CYC) @(negedge mclk_i);
      link_b.host_sda_oe_n = (k > 0) ? b[k - 1] : 1'b1; // MSB first, then release
      repeat (QTR_CYC) @(negedge mclk_i);
      link_b.serial_clock = 1'b1;
      repeat (2 * QTR_CYC) @(negedge mclk_i);
      if (k == 0)
        seen = link_b.serial_data_line;
    end
    link_b.serial_clock = 1'b0;
    repeat (QTR_CYC) @(negedge mclk_i);
    link_b.host_sda_oe_n = 1'b0;
    repeat (QTR_CYC) @(negedge mclk_i);
    link_b.serial_clock = 1'b1;
    repeat (QTR_CYC) @(negedge mclk_i);
    link_b.host_sda_oe_n = 1'b1;
    repeat (2 * QTR_CYC) @(negedge mclk_i);
    cmp_flag("probe ack", quiet, seen);
  endtask : probe

  // Main sequence: write, read back, pointer follow-on, wrap, address match
  initial begin
    cmd_valid = 1'b0;
    cmd_kind = CMD_WRITE;
    cmd_addr = 16'h0000;
    cmd_wdata = 16'h0000;
    cmd_len = 8'h00;
    reg_rdata = 16'h0000;
    ptr = 16'h0000;
    first = 1'b0;
    pscl = 1'b1;
    psda = 1'b1;
    link_b.serial_clock = 1'b1;
    link_b.host_sda_o = 1'b0;
    link_b.host_sda_oe_n = 1'b1;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    base = 16'($random(seed));
    run(CMD_WRITE, base, 2);
    run(CMD_RAND_READ, base, 2);
    run(CMD_CUR_READ, 16'h0000, 1);
    run(CMD_WRITE, 16'hFFFF, 1);
    run(CMD_CUR_READ, 16'h0000, 1);
    probe(8'h7C, 1'b1);
    probe(8'h7A, 1'b0);
    repeat (600) @(negedge mclk_i);
    cmp("notes left", 16'h0000, 16'(wq.size() + rq.size() + aq.size()));
    close_out();
  end
endmodule : testbench
